// ===== verilog/csad_pkg.sv
// Constants and types of the chip select area decoder
package csad_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_AREA0_BASE     = 8'h94;
    localparam logic [7:0]  IDX_AREA0_SIZE     = 8'h95;
    localparam logic [7:0]  IDX_AREA1_BASE     = 8'h96;
    localparam logic [7:0]  IDX_AREA1_SIZE     = 8'h97;
    localparam logic [7:0]  IDX_AREA2_BASE     = 8'h98;
    localparam logic [7:0]  IDX_AREA2_SIZE     = 8'h99;
    localparam logic [7:0]  IDX_AREA3_BASE     = 8'h9a;
    localparam logic [7:0]  IDX_AREA3_SIZE     = 8'h9b;
    localparam logic [7:0]  IDX_AREA0_CONTROL  = 8'h9c;
    localparam logic [7:0]  IDX_AREA3_CONTROL  = 8'h9f;
    localparam logic [7:0]  IDX_OUTSIDE_CTRL   = 8'ha0;
    localparam logic [7:0]  IDX_PIN_FUNCTION   = 8'ha1;

    localparam int          ADDR_W             = 12;
    localparam int          NUM_AREAS          = 4;

    // Reset values
    localparam logic [7:0]  RST_BASE           = 8'hff;
    localparam logic [7:0]  RST_SIZE_MASK      = 8'hff;
    localparam logic [7:0]  RST_CTRL_OFF       = 8'h00;
    localparam logic [7:0]  RST_CTRL_AREA2     = 8'h80;
    localparam logic [7:0]  RST_OUTSIDE_CTRL   = 8'h00;
    localparam logic [3:0]  RST_PIN_FUNCTION   = 4'h0;

    // Control register fields
    localparam int          CTL_ENABLE         = 7;
    localparam int          CTL_MODE           = 6;
    localparam int          CTL_WAVE_HI        = 5;
    localparam int          CTL_WAVE_LO        = 4;
    localparam int          CTL_BUS8           = 3;
    localparam int          CTL_WAIT_HI        = 2;

    // Area two fixed window while its mode bit is clear
    localparam logic [23:0] AREA2_FIXED_LOW    = 24'h0008a0;
    localparam logic [23:0] AREA2_TOP_SHORT    = 24'hfeffff;
    localparam logic [23:0] AREA2_TOP_FULL     = 24'hffffff;

    typedef enum logic [1:0] {
        CSAD_WAVE_ROM   = 2'b00,
        CSAD_WAVE_PSEUDO_STATIC_MEMORY = 2'b01
    } csad_wave_t;

    function automatic logic [ADDR_W-1:0] csad_byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

endpackage

// ===== verilog/csad_area_if.sv
// Link between the decoder core and one area comparator
`timescale 1ns/1ps
`default_nettype none
interface csad_area_if;
    logic [23:0] addr;
    logic [7:0]  base;
    logic [7:0]  size_mask;
    logic        enable;
    logic        mode;
    logic        hit;

    modport core (output addr, output base, output size_mask, output enable,
                  output mode, input hit);
    modport cmp  (input addr, input base, input size_mask, input enable,
                  input mode, output hit);
endinterface
`default_nettype wire

// ===== verilog/csad_area_match.sv
// One area comparator: base and per-bit mask against the bus address
`timescale 1ns/1ps
`default_nettype none
module csad_area_match
    import csad_pkg::*;
#(
    parameter int       AREA     = 0,
    parameter bit       TOP_FULL = 1'b0
) (
    csad_area_if.cmp    area
);

    localparam logic [23:0] AREA2_TOP = TOP_FULL ? AREA2_TOP_FULL : AREA2_TOP_SHORT;

    // Expands a mask register into ignored address bits 23..8
    function automatic logic [15:0] ignore_bits(input logic [7:0] m);
        logic [15:0] ig;
        ig = 16'h0000;
        if (AREA == 0) begin
            // [RL5] Area zero mapping
            ig[12:7] = m[7:2];
            ig[6:1]  = {6{m[1]}};
            ig[0]    = m[0];
        end else if (AREA == 1) begin
            // [RL6] Area one mapping
            ig[13:8] = m[7:2];
            ig[7:1]  = {7{m[1]}};
            ig[0]    = m[0];
        end else begin
            // [RL7] Areas two, three
            ig[14:7] = m[7:0];
            // Smallest area is 32 Kbytes, so bits 14..8 never take part
            ig[6:0]  = 7'h7f;
        end
        return ig;
    endfunction

    logic [15:0] diff;
    logic        masked_hit;
    logic        fixed_hit;

    // [RL3] Base low bits zero
    assign diff       = area.addr[23:8] ^ {area.base, 8'h00};
    // [RL4] Masked bits excluded
    // [RL19] Upper bits always compared
    assign masked_hit = (diff & ~ignore_bits(area.size_mask)) == 16'h0000;
    // [RL11] Fixed area two window
    assign fixed_hit  = (area.addr >= AREA2_FIXED_LOW) && (area.addr <= AREA2_TOP);

    // [RL19] Disabled area never hits
    assign area.hit = area.enable &&
                      ((AREA == 2 && !area.mode) ? fixed_hit : masked_hit);

endmodule // csad_area_match
`default_nettype wire

// ===== verilog/csad_decoder.sv
// Chip select area decoder with APB register file
// Behaviour
// [RL1] Four programmable areas, each with own width and wait, plus a default.
// [RL2] Each bus cycle compares address to areas; match drives select and settings.
// [RL3] Base registers hold address bits 23..16; lower bits are zero.
// [RL4] Only address bits with mask bit zero take part in comparison.
// [RL5] Area zero mask covers bits 20..8, sizes 256 bytes to 2 Mbytes.
// [RL6] Area one mask covers bits 21..8, sizes 256 bytes to 4 Mbytes.
// [RL7] Areas two and three mask bits 22..15, 32 Kbytes to 8 Mbytes.
// [RL8] Software derives area zero mask from end minus start, bits 20..8.
// [RL9] Reset loads all base and mask registers with all ones.
// [RL10] Reset disables areas zero, one and three.
// [RL11] Reset enables area two, mode zero, over its fixed address window.
// [RL12] Unmatched addresses use the outside-area width and wait settings.
// [RL13] Select drives its pin only once its pin function bit is set.
// [RL14] Select waveform follows the area's ROM or pseudo-static style.
// [RL15] Lowest numbered matching area wins.
// [RL16] Control bit 7 is the area master enable.
// [RL17] Control bit 3 selects bus width: 0 is 16-bit, 1 is 8-bit.
// [RL18] Control bits 5..4 select waveform: 00 ROM style, 01 pseudo-static.
// [RL19] Unmaskable upper bits always compared; disabled areas never match.
`timescale 1ns/1ps
`default_nettype none
module csad_decoder
    import csad_pkg::*;
#(
    parameter bit                   AREA2_TOP_FULL = 1'b0
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Bus cycle from the CPU side
    input  wire logic               bus_cycle_i,
    input  wire logic               bus_strobe_i,
    input  wire logic [23:0]        bus_addr_i,
    // Chip select pins and cycle settings
    output logic      [3:0]         area_select_n_o,
    output logic      [3:0]         area_select_oe_n_o,
    output logic                    bus_8bit_o,
    output logic      [2:0]         wait_count_o,
    output logic                    area_hit_o,
    output logic      [1:0]         area_index_o
);

    typedef struct packed {
        logic [3:0][7:0] base;
        logic [3:0][7:0] size_mask;
        logic [3:0][7:0] control;
        logic [7:0]      outside;
        logic [3:0]      pin_function;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic [3:0]      select_n;
        logic [3:0]      select_oe_n;
        logic            bus_8bit;
        logic [2:0]      wait_count;
        logic            hit;
        logic [1:0]      index;
    } csad_state_t;

    csad_state_t st;
    csad_state_t next_st;

    logic [3:0]  hits;
    csad_area_if aif[NUM_AREAS] ();

    genvar g;
    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_area
            assign aif[g].addr      = bus_addr_i;
            assign aif[g].base      = st.base[g];
            assign aif[g].size_mask = st.size_mask[g];
            // [RL16] Master enable bit
            assign aif[g].enable    = st.control[g][CTL_ENABLE];
            assign aif[g].mode      = st.control[g][CTL_MODE];
            assign hits[g]          = aif[g].hit;
            csad_area_match #(
                .AREA     (g),
                .TOP_FULL (AREA2_TOP_FULL)
            ) u_match (
                .area     (aif[g].cmp)
            );
        end
    endgenerate

    // Maps an APB byte address to a register slot; returns valid flag
    function automatic logic decode(input logic [ADDR_W-1:0] a, output logic [7:0] idx);
        idx = a[ADDR_W-3:2];
        // Upper address bits must be clear, or registers would alias
        return (a[ADDR_W-1:ADDR_W-2] == 2'b00) && (a[1:0] == 2'b00) &&
               (idx >= IDX_AREA0_BASE) && (idx <= IDX_PIN_FUNCTION);
    endfunction

    function automatic logic [7:0] read_reg(input csad_state_t s, input logic [7:0] idx);
        logic [7:0] off;
        off = idx - IDX_AREA0_BASE;
        if (idx <= IDX_AREA3_SIZE) begin
            read_reg = off[0] ? s.size_mask[off[2:1]] : s.base[off[2:1]];
        end else if (idx <= IDX_AREA3_CONTROL) begin
            read_reg = s.control[2'(idx - IDX_AREA0_CONTROL)];
        end else if (idx == IDX_OUTSIDE_CTRL) begin
            read_reg = s.outside;
        end else begin
            read_reg = {4'h0, s.pin_function};
        end
    endfunction

    always_comb begin
        logic [7:0] idx;
        logic [7:0] off;
        logic       valid;
        logic       setup;
        logic       access;
        logic [7:0] sel_ctrl;
        logic [3:0] win;
        next_st  = st;
        idx      = 8'h00;
        off      = 8'h00;
        valid    = decode(paddr_i, idx);
        setup    = psel_i && !penable_i;
        access   = psel_i && penable_i && st.pready;
        sel_ctrl = st.outside;
        win      = 4'h0;

        // Answer in the access phase right after setup
        next_st.pready  = setup;
        next_st.pslverr = setup && !valid;
        if (setup) begin
            next_st.prdata = (valid && !pwrite_i) ? {24'h000000, read_reg(st, idx)}
                                                  : 32'h00000000;
        end

        if (access && pwrite_i && valid) begin
            off = idx - IDX_AREA0_BASE;
            if (idx <= IDX_AREA3_SIZE) begin
                if (off[0]) begin
                    // [RL8] Mask value written as given
                    next_st.size_mask[off[2:1]] = pwdata_i[7:0];
                end else begin
                    // [RL3] Base high bits
                    next_st.base[off[2:1]] = pwdata_i[7:0];
                end
            end else if (idx <= IDX_AREA3_CONTROL) begin
                // [RL1] Per-area settings
                next_st.control[2'(idx - IDX_AREA0_CONTROL)] = pwdata_i[7:0];
            end else if (idx == IDX_OUTSIDE_CTRL) begin
                // Only width and wait fields exist here
                next_st.outside = {4'h0, pwdata_i[3:0]};
            end else begin
                next_st.pin_function = pwdata_i[3:0];
            end
        end

        // [RL15] Lowest area wins
        for (int i = NUM_AREAS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                win = 4'h0;
                win[i] = 1'b1;
                sel_ctrl = st.control[i];
                next_st.index = 2'(i);
            end
        end

        // [RL2] Per-cycle decode
        if (bus_cycle_i) begin
            next_st.hit = |hits;
            // [RL12] Outside-area default
            // [RL17] Bus width bit
            next_st.bus_8bit   = sel_ctrl[CTL_BUS8];
            next_st.wait_count = sel_ctrl[CTL_WAIT_HI:0];
            if (!(|hits)) begin
                next_st.index = 2'b00;
            end
        end else begin
            next_st.hit   = 1'b0;
            next_st.index = 2'b00;
        end

        for (int i = 0; i < NUM_AREAS; i++) begin
            // [RL14] Waveform per area
            // [RL18] ROM holds for cycle, pseudo-static follows strobe
            if (csad_wave_t'(st.control[i][CTL_WAVE_HI:CTL_WAVE_LO]) == CSAD_WAVE_PSEUDO_STATIC_MEMORY) begin
                next_st.select_n[i] = !(bus_cycle_i && win[i] && bus_strobe_i);
            end else begin
                next_st.select_n[i] = !(bus_cycle_i && win[i]);
            end
            // [RL13] Pin driven only when function bit set
            next_st.select_oe_n[i] = !st.pin_function[i];
        end

        if (rst_i) begin
            // [RL9] All ones on reset
            next_st.base         = {NUM_AREAS{RST_BASE}};
            next_st.size_mask    = {NUM_AREAS{RST_SIZE_MASK}};
            // [RL10] Areas zero, one, three off
            // [RL11] Area two on, mode zero
            next_st.control      = {RST_CTRL_OFF, RST_CTRL_AREA2, RST_CTRL_OFF, RST_CTRL_OFF};
            next_st.outside      = RST_OUTSIDE_CTRL;
            next_st.pin_function = RST_PIN_FUNCTION;
            next_st.prdata       = 32'h00000000;
            next_st.pready       = 1'b0;
            next_st.pslverr      = 1'b0;
            next_st.select_n     = 4'hf;
            next_st.select_oe_n  = 4'hf;
            next_st.bus_8bit     = 1'b0;
            next_st.wait_count   = 3'h0;
            next_st.hit          = 1'b0;
            next_st.index        = 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign prdata_o           = st.prdata;
    assign pready_o           = st.pready;
    assign pslverr_o          = st.pslverr;
    assign area_select_n_o    = st.select_n;
    assign area_select_oe_n_o = st.select_oe_n;
    assign bus_8bit_o         = st.bus_8bit;
    assign wait_count_o       = st.wait_count;
    assign area_hit_o         = st.hit;
    assign area_index_o       = st.index;

endmodule // csad_decoder
`default_nettype wire

// ===== tb/csad_mem_model.sv
// Far-side memory chips as seen through the select pins
`timescale 1ns/1ps
`default_nettype none
module csad_mem_model (
    input  wire logic [3:0] select_n_i,
    input  wire logic [3:0] oe_n_i,
    output logic      [3:0] pin_n_o
);
    // Pull-up when released
    // A released pin floats to the pull-up, never to the last driven level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_n_o[i] = oe_n_i[i] ? 1'b1 : select_n_i[i];
        end
    end
endmodule // csad_mem_model
`default_nettype wire

// ===== tb/csad_decoder_assertions.sv
// Port checker of the area decoder
`timescale 1ns/1ps
`default_nettype none
module csad_decoder_assertions
    import csad_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic              bus_cycle_i,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic [3:0]        area_select_n_o,
    input wire logic [3:0]        area_select_oe_n_o,
    input wire logic              bus_8bit_o,
    input wire logic [2:0]        wait_count_o,
    input wire logic              area_hit_o,
    input wire logic [1:0]        area_index_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    idle_select_a: assert property (
        !bus_cycle_i |=> area_select_n_o == 4'hf && !area_hit_o) else $error("select without cycle");
    one_select_a: assert property (
        area_select_n_o != 4'hf |-> area_hit_o && area_select_n_o == ~(4'h1 << area_index_o))
        else $error("select does not match index");
    nohit_index_a: assert property (
        !area_hit_o |-> area_index_o == 2'h0) else $error("index without hit");
    hold_width_a: assert property (
        !bus_cycle_i |=> $stable(bus_8bit_o) && $stable(wait_count_o)) else $error("settings moved");
    ready_pulse_a: assert property (
        psel_i && !penable_i |=> pready_o ##1 !pready_o) else $error("ready pulse wrong");
    err_ready_a: assert property (
        pslverr_o |-> pready_o) else $error("error without ready");
    misalign_err_a: assert property (
        psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_o) else $error("misaligned accepted");
    reset_state_a: assert property (
        $past(rst_i) |-> area_select_oe_n_o == 4'hf && area_select_n_o == 4'hf && wait_count_o == 3'h0)
        else $error("pins not idle after reset");
    hit_cause_a: assert property (
        area_hit_o |-> $past(bus_cycle_i)) else $error("hit without cycle");
endmodule // csad_decoder_assertions

bind csad_decoder csad_decoder_assertions u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .paddr_i,
    .bus_cycle_i, .pready_o, .pslverr_o, .area_select_n_o, .area_select_oe_n_o, .bus_8bit_o,
    .wait_count_o, .area_hit_o, .area_index_o);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the area decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import csad_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [23:0] baddr = 24'h0;
    logic [31:0] prdata, rd;
    logic [3:0]  sel_n, oe_n, pin_n;
    logic [2:0]  wc;
    logic [1:0]  idx;
    logic        pready, pslverr, er, b8, hit;
    int          err_count = 0;
    int          check_count = 0;

    always #5 clk_i = ~clk_i;

    csad_decoder #(.AREA2_TOP_FULL(1'b0)) uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .bus_cycle_i(cyc), .bus_strobe_i(stb),
        .bus_addr_i(baddr), .area_select_n_o(sel_n), .area_select_oe_n_o(oe_n),
        .bus_8bit_o(b8), .wait_count_o(wc), .area_hit_o(hit), .area_index_o(idx));
    csad_mem_model mem (.select_n_i(sel_n), .oe_n_i(oe_n), .pin_n_o(pin_n));

    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Ready is looked at mid-cycle, so the value standing at the next edge is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(negedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge clk_i);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // Outputs settle one cycle after the address is taken
    task automatic bus(input logic [23:0] a, input logic s);
        @(posedge clk_i);
        cyc   <= 1'b1;
        baddr <= a;
        stb   <= s;
        @(posedge clk_i);
        cyc <= 1'b0;
        #1;
    endtask

    task automatic dec(input logic [3:0] s, input logic h, input logic [1:0] i);
        check("select_n", 32'(sel_n), 32'(s));
        check("hit", 32'(hit), 32'(h));
        check("index", 32'(idx), 32'(i));
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ba(IDX_AREA0_BASE + 8'(i)), 8'h00);
            check("base_mask", rd, 32'hff);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ba(IDX_AREA0_CONTROL + 8'(i)), 8'h00);
            check("control", rd, (i == 2) ? 32'h80 : 32'h0);
        end
        bus(24'h100000, 1'b0);
        dec(4'hb, 1'b1, 2'd2);
        check("width", 32'(b8), 32'h0);
        check("pin", 32'(pin_n), 32'hf);
        bus(24'hff0000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        bus(24'h00089f, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        bus(24'h0008a0, 1'b0);
        dec(4'hb, 1'b1, 2'd2);
        $display("test reset done");
    endtask

    task automatic t_area0();
        logic [12:0] d;
        d = 13'((24'h01ffff - 24'h010000) >> 8);
        apb(1'b1, ba(IDX_AREA0_BASE), 8'h01);
        apb(1'b1, ba(IDX_AREA0_SIZE), {d[12:7], d[1], d[0]});
        apb(1'b1, ba(IDX_AREA0_CONTROL), 8'h8b);
        apb(1'b1, ba(IDX_PIN_FUNCTION), 8'h0f);
        apb(1'b0, ba(IDX_AREA0_SIZE), 8'h00);
        check("mask0", rd, 32'h07);
        bus(24'h01ffff, 1'b0);
        dec(4'he, 1'b1, 2'd0);
        check("width", 32'(b8), 32'h1);
        check("wait", 32'(wc), 32'h3);
        check("pin", 32'(pin_n), 32'he);
        bus(24'h020000, 1'b0);
        dec(4'hb, 1'b1, 2'd2);
        bus(24'h810000, 1'b0);
        dec(4'hb, 1'b1, 2'd2);
        $display("test area0 done");
    endtask

    task automatic t_outside();
        apb(1'b1, ba(IDX_OUTSIDE_CTRL), 8'h0a);
        apb(1'b1, ba(IDX_AREA0_CONTROL + 8'h2), 8'h00);
        bus(24'h500000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        check("width", 32'(b8), 32'h1);
        check("wait", 32'(wc), 32'h2);
        apb(1'b1, ba(IDX_AREA0_CONTROL), 8'h0b);
        bus(24'h010000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        $display("test outside done");
    endtask

    task automatic t_area3();
        apb(1'b1, ba(IDX_AREA3_BASE), 8'h40);
        apb(1'b1, ba(IDX_AREA3_SIZE), 8'h01);
        apb(1'b1, ba(IDX_AREA3_CONTROL), 8'h95);
        bus(24'h408000, 1'b0);
        dec(4'hf, 1'b1, 2'd3);
        check("wait", 32'(wc), 32'h5);
        bus(24'h408000, 1'b1);
        dec(4'h7, 1'b1, 2'd3);
        bus(24'h40ff00, 1'b1);
        dec(4'h7, 1'b1, 2'd3);
        bus(24'h410000, 1'b1);
        dec(4'hf, 1'b0, 2'd0);
        $display("test area3 done");
    endtask

    task automatic t_area12();
        apb(1'b1, ba(IDX_AREA1_BASE), 8'h20);
        apb(1'b1, ba(IDX_AREA1_SIZE), 8'h03);
        apb(1'b1, ba(IDX_AREA0_CONTROL + 8'h1), 8'h8c);
        bus(24'h20ffff, 1'b0);
        dec(4'hd, 1'b1, 2'd1);
        check("wait", 32'(wc), 32'h4);
        bus(24'h210000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        apb(1'b1, ba(IDX_AREA2_BASE), 8'h30);
        apb(1'b1, ba(IDX_AREA2_SIZE), 8'h00);
        apb(1'b1, ba(IDX_AREA0_CONTROL + 8'h2), 8'hc1);
        bus(24'h307f00, 1'b0);
        dec(4'hb, 1'b1, 2'd2);
        check("width", 32'(b8), 32'h0);
        check("wait", 32'(wc), 32'h1);
        bus(24'h308000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        bus(24'h100000, 1'b0);
        dec(4'hf, 1'b0, 2'd0);
        $display("test area1 area2 done");
    endtask

    task automatic t_unmapped();
        apb(1'b0, 12'h3f0, 8'h00);
        check("err", 32'(er), 32'h1);
        check("data", rd, 32'h0);
        apb(1'b0, ba(IDX_AREA0_BASE) | 12'h400, 8'h00);
        check("alias_err", 32'(er), 32'h1);
        apb(1'b1, ba(IDX_AREA0_BASE) | 12'h001, 8'h55);
        apb(1'b0, ba(IDX_AREA0_BASE), 8'h00);
        check("base0", rd, 32'h01);
        $display("test unmapped done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_area0();
        t_outside();
        t_area3();
        t_area12();
        t_unmapped();
        stop_test();
    end

    // Whole run needs about 140 cycles; this cuts a hang short
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
